// >>> design/ptbd_decoder.v
`include "ptbd_map.vh"

// Operation
// - Each 64-bit word fully describes one 4x4 RGBA tile.
// - Four modes, differential, T, H, planar, chosen from block bits.
// - Extract three 5-bit base fields and three 3-bit deltas.
// - Bases are unsigned 0..31, deltas two's complement -4..+3.
// - Red overflow gives T, then green gives H, blue planar, else differential.
// - Bit 32 clear splits into left/right halves, set into top/bottom.
// - First sub-block base widens 5-bit fields by replicating top three bits.
// - Second sub-block base is field plus delta, widened the same way.
// - Table codes at bits 39..37 and 36..34 pick one of eight tables.
// - Opaque bit 33 selects between the two modifier table sets.
// - Modifier tables are fixed constant lookup logic.
// - Index MSBs in bits 31..16, LSBs in bits 15..0, per pixel.
// - Index bit positions never depend on the split flag.
// - Opaque tables hold listed values; transparent set zeroes middle entries.
// - Index 11 large negative, 10 small negative, 00 small positive, 01 large.
// - Modifier added to every channel, each result clamped to 0..255.
// - Transparent bit with index 10 in differential mode yields zero alpha and zero color.
module ptbd_decoder (
    input wire sys_clk,
    input wire rst,
    input wire clkEn,
    input wire blkValid,
    input wire [63:0] blkData,
    input wire [1:0] pixX,
    input wire [1:0] pixY,
    output reg resValid_q,
    output wire [7:0] resRed_q,
    output wire [7:0] resGreen_q,
    output wire [7:0] resBlue_q,
    output reg [7:0] resAlpha_q,
    output reg [1:0] resMode_q
);
    // Field extraction
    wire [4:0] redBase = blkData[`PTBD_RED_HI:`PTBD_RED_LO];
    wire [2:0] red_delta = blkData[`PTBD_RDELTA_HI:`PTBD_RDELTA_LO];
    wire [4:0] greenBase = blkData[`PTBD_GREEN_HI:`PTBD_GREEN_LO];
    wire [2:0] green_delta = blkData[`PTBD_GDELTA_HI:`PTBD_GDELTA_LO];
    wire [4:0] blueBase = blkData[`PTBD_BLUE_HI:`PTBD_BLUE_LO];
    wire [2:0] blue_delta = blkData[`PTBD_BDELTA_HI:`PTBD_BDELTA_LO];
    wire [2:0] first_subblock_table_code =
        blkData[`PTBD_TAB1_HI:`PTBD_TAB1_LO];
    wire [2:0] second_subblock_table_code =
        blkData[`PTBD_TAB2_HI:`PTBD_TAB2_LO];
    wire opaque_flag = blkData[`PTBD_OPAQUE_BIT];
    wire subblock_split_flag = blkData[`PTBD_SPLIT_BIT];

    // Seven-bit signed sums: bit 6 set means below zero, bit 5 above 31
    wire [6:0] redSum = {2'b00, redBase} + {{4{red_delta[2]}}, red_delta};
    wire [6:0] greenSum =
        {2'b00, greenBase} + {{4{green_delta[2]}}, green_delta};
    wire [6:0] blueSum = {2'b00, blueBase} + {{4{blue_delta[2]}}, blue_delta};
    wire redOut = redSum[6] | redSum[5];
    wire greenOut = greenSum[6] | greenSum[5];
    wire blueOut = blueSum[6] | blueSum[5];

    // Pixels are numbered column first: a is (0,0), b is (0,1), e is (1,0)
    wire [3:0] pixNum = {pixX, pixY};
    wire idxMsb = blkData[`PTBD_IDX_MSB_BASE + pixNum];
    wire idxLsb = blkData[`PTBD_IDX_LSB_BASE + pixNum];
    wire [1:0] pixIdx = {idxMsb, idxLsb};

    reg [1:0] mode;
    reg secondSub;
    reg [4:0] selR;
    reg [4:0] selG;
    reg [4:0] selB;
    reg [2:0] tabCode;
    reg [7:0] largeMag;
    reg [7:0] smallMag;
    reg [8:0] modVal;
    reg kill;

    always @* begin
        if (redOut) begin
            mode = `PTBD_MODE_T;
        end else if (greenOut) begin
            mode = `PTBD_MODE_H;
        end else if (blueOut) begin
            mode = `PTBD_MODE_PLANAR;
        end else begin
            mode = `PTBD_MODE_DIFF;
        end
    end

    always @* begin
        if (subblock_split_flag) begin
            secondSub = pixY[1];
        end else begin
            secondSub = pixX[1];
        end
        // Sums cannot wrap here because differential mode was chosen
        if (secondSub) begin
            selR = redSum[4:0];
            selG = greenSum[4:0];
            selB = blueSum[4:0];
            tabCode = second_subblock_table_code;
        end else begin
            selR = redBase;
            selG = greenBase;
            selB = blueBase;
            tabCode = first_subblock_table_code;
        end
    end

    always @* begin
        case (tabCode)
            3'h0: begin
                largeMag = 8'h08;
                smallMag = 8'h02;
            end
            3'h1: begin
                largeMag = 8'h11;
                smallMag = 8'h05;
            end
            3'h2: begin
                largeMag = 8'h1D;
                smallMag = 8'h09;
            end
            3'h3: begin
                largeMag = 8'h2A;
                smallMag = 8'h0D;
            end
            3'h4: begin
                largeMag = 8'h3C;
                smallMag = 8'h12;
            end
            3'h5: begin
                largeMag = 8'h50;
                smallMag = 8'h18;
            end
            3'h6: begin
                largeMag = 8'h6A;
                smallMag = 8'h21;
            end
            3'h7: begin
                largeMag = 8'hB7;
                smallMag = 8'h2F;
            end
            default: begin
                largeMag = 8'h00;
                smallMag = 8'h00;
            end
        endcase
    end

    always @* begin
        // Transparent blocks zero the middle entries of every table
        case (pixIdx)
            `PTBD_IDX_LARGE_NEG: modVal = 9'h000 - {1'b0, largeMag};
            `PTBD_IDX_SMALL_NEG: modVal = opaque_flag ?
                9'h000 - {1'b0, smallMag} : 9'h000;
            `PTBD_IDX_SMALL_POS: modVal = opaque_flag ?
                {1'b0, smallMag} : 9'h000;
            `PTBD_IDX_LARGE_POS: modVal = {1'b0, largeMag};
            default: modVal = 9'h000;
        endcase
        kill = ~opaque_flag && (pixIdx == `PTBD_IDX_SMALL_NEG);
    end

    // Stage one registers
    reg s1Valid_q;
    reg [1:0] s1Mode_q;
    reg [7:0] s1Red_q;
    reg [7:0] s1Green_q;
    reg [7:0] s1Blue_q;
    reg [8:0] s1Mod_q;
    reg s1Kill_q;
    wire isDiff = (mode == `PTBD_MODE_DIFF);

    // Modes outside differential are reported but decode as opaque black
    always @(posedge sys_clk) begin
        if (rst) begin
            s1Valid_q <= 1'b0;
            s1Mode_q <= `PTBD_MODE_DIFF;
            s1Red_q <= `PTBD_CHAN_RESET;
            s1Green_q <= `PTBD_CHAN_RESET;
            s1Blue_q <= `PTBD_CHAN_RESET;
            s1Mod_q <= 9'h000;
            s1Kill_q <= 1'b0;
        end else if (clkEn) begin
            s1Valid_q <= blkValid;
            if (blkValid) begin
                s1Mode_q <= mode;
                s1Red_q <= isDiff ? {selR, selR[4:2]} : 8'h00;
                s1Green_q <= isDiff ? {selG, selG[4:2]} : 8'h00;
                s1Blue_q <= isDiff ? {selB, selB[4:2]} : 8'h00;
                s1Mod_q <= isDiff ? modVal : 9'h000;
                s1Kill_q <= isDiff & kill;
            end
        end
    end

    // Stage two: add and clamp inside each channel
    ptbd_channel uRed (
        .sysClk(sys_clk),
        .rst(rst),
        .clkEn(clkEn),
        .load(s1Valid_q),
        .base(s1Red_q),
        .modifier(s1Mod_q),
        .kill(s1Kill_q),
        .chan_q(resRed_q)
    );

    ptbd_channel uGreen (
        .sysClk(sys_clk),
        .rst(rst),
        .clkEn(clkEn),
        .load(s1Valid_q),
        .base(s1Green_q),
        .modifier(s1Mod_q),
        .kill(s1Kill_q),
        .chan_q(resGreen_q)
    );

    ptbd_channel uBlue (
        .sysClk(sys_clk),
        .rst(rst),
        .clkEn(clkEn),
        .load(s1Valid_q),
        .base(s1Blue_q),
        .modifier(s1Mod_q),
        .kill(s1Kill_q),
        .chan_q(resBlue_q)
    );

    always @(posedge sys_clk) begin
        if (rst) begin
            resValid_q <= 1'b0;
            resAlpha_q <= `PTBD_ALPHA_NONE;
            resMode_q <= `PTBD_MODE_DIFF;
        end else if (clkEn) begin
            resValid_q <= s1Valid_q;
            if (s1Valid_q) begin
                resAlpha_q <= s1Kill_q ?
                    `PTBD_ALPHA_NONE : `PTBD_ALPHA_FULL;
                resMode_q <= s1Mode_q;
            end
        end
    end
endmodule

// >>> design/ptbd_map.vh
`ifndef PTBD_MAP_VH
`define PTBD_MAP_VH

// High word field positions
`define PTBD_RED_HI 63
`define PTBD_RED_LO 59
`define PTBD_RDELTA_HI 58
`define PTBD_RDELTA_LO 56
`define PTBD_GREEN_HI 55
`define PTBD_GREEN_LO 51
`define PTBD_GDELTA_HI 50
`define PTBD_GDELTA_LO 48
`define PTBD_BLUE_HI 47
`define PTBD_BLUE_LO 43
`define PTBD_BDELTA_HI 42
`define PTBD_BDELTA_LO 40
`define PTBD_TAB1_HI 39
`define PTBD_TAB1_LO 37
`define PTBD_TAB2_HI 36
`define PTBD_TAB2_LO 34
`define PTBD_OPAQUE_BIT 33
`define PTBD_SPLIT_BIT 32

// Low word pixel index planes
`define PTBD_IDX_MSB_BASE 16
`define PTBD_IDX_LSB_BASE 0

// Block modes
`define PTBD_MODE_DIFF 2'h0
`define PTBD_MODE_T 2'h1
`define PTBD_MODE_H 2'h2
`define PTBD_MODE_PLANAR 2'h3

// Pixel index codes
`define PTBD_IDX_SMALL_POS 2'h0
`define PTBD_IDX_LARGE_POS 2'h1
`define PTBD_IDX_SMALL_NEG 2'h2
`define PTBD_IDX_LARGE_NEG 2'h3

// Reset values and pipeline depth
`define PTBD_CHAN_RESET 8'h00
`define PTBD_ALPHA_FULL 8'hFF
`define PTBD_ALPHA_NONE 8'h00
`define PTBD_LATENCY 2

`endif

// >>> design/ptbd_channel.v
`include "ptbd_map.vh"

// One color channel: base plus signed modifier, clamped, registered
module ptbd_channel (
    input wire sysClk,
    input wire rst,
    input wire clkEn,
    input wire load,
    input wire [7:0] base,
    input wire [8:0] modifier,
    input wire kill,
    output reg [7:0] chan_q
);
    reg [9:0] sum;
    reg [7:0] chan_d;

    always @* begin
        sum = {2'b00, base} + {modifier[8], modifier};
        if (kill) begin
            chan_d = 8'h00;
        end else if (sum[9]) begin
            chan_d = 8'h00;
        end else if (sum[8]) begin
            chan_d = 8'hFF;
        end else begin
            chan_d = sum[7:0];
        end
    end

    always @(posedge sysClk) begin
        if (rst) begin
            chan_q <= `PTBD_CHAN_RESET;
        end else if (clkEn && load) begin
            chan_q <= chan_d;
        end
    end
endmodule

// >>> tb/ptbd_decoder_assertions.sv
module ptbd_decoder_checker (
    input logic sys_clk,
    input logic rst,
    input logic clkEn,
    input logic blkValid,
    input logic [63:0] blkData,
    input logic [1:0] pixX,
    input logic [1:0] pixY,
    input logic resValid_q,
    input logic [7:0] resRed_q,
    input logic [7:0] resGreen_q,
    input logic [7:0] resBlue_q,
    input logic [7:0] resAlpha_q,
    input logic [1:0] resMode_q
);
    timeunit 1ns;
    timeprecision 1ps;
    function automatic logic [1:0] modeOf(logic [63:0] d);
        int s;
        for (int c = 0; c < 3; c++) begin
            s = int'(d[63-8*c -: 5]) + int'($signed(d[58-8*c -: 3]));
            if (s < 0 || s > 31) return 2'(c + 1);
        end
        return 2'h0;
    endfunction
    wire take = clkEn && blkValid;
    wire [3:0] n = {pixX, pixY};
    wire [1:0] modeIn = modeOf(blkData);
    wire killIn = !blkData[33] && blkData[16+n] && !blkData[n] && modeIn == 0;
    wire [23:0] rgb = {resRed_q, resGreen_q, resBlue_q};
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_lat; take ##1 clkEn |=> resValid_q; endproperty
    a_lat: assert property (p_lat) else $error("result late");
    property p_mode;
        take ##1 clkEn |=> resMode_q == $past(modeIn, 2);
    endproperty
    a_mode: assert property (p_mode) else $error("mode wrong");
    property p_opq; take && blkData[33] ##1 clkEn |=> resAlpha_q == 8'hFF;
    endproperty
    a_opq: assert property (p_opq) else $error("opaque alpha");
    property p_kill; take && killIn ##1 clkEn |=> resAlpha_q == 8'h00;
    endproperty
    a_kill: assert property (p_kill) else $error("alpha not cut");
    property p_zero; resValid_q && resAlpha_q == 8'h00 |-> rgb == 24'h0;
    endproperty
    a_zero: assert property (p_zero) else $error("color not cut");
    property p_other; resValid_q && resMode_q != 2'h0 |-> rgb == 24'h0 &&
        resAlpha_q == 8'hFF; endproperty
    a_other: assert property (p_other) else $error("odd mode out");
    property p_hold; !clkEn |=> $stable({resValid_q, rgb, resAlpha_q});
    endproperty
    a_hold: assert property (p_hold) else $error("moved in stall");
    property p_pulse; clkEn && !take ##1 clkEn |=> !resValid_q; endproperty
    a_pulse: assert property (p_pulse) else $error("spare strobe");
    property p_rst; disable iff (1'b0) rst |=> !resValid_q && rgb == 24'h0 &&
        resAlpha_q == 8'h00 && resMode_q == 2'h0; endproperty
    a_rst: assert property (p_rst) else $error("reset value");
    c_kill: cover property (take && killIn);
    c_planar: cover property (resValid_q && resMode_q == 2'h3);
    c_stall: cover property (resValid_q && !clkEn);
endmodule
bind ptbd_decoder ptbd_decoder_checker i_ptbd_decoder_checker (
    .sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .blkValid(blkValid),
    .blkData(blkData), .pixX(pixX), .pixY(pixY), .resValid_q(resValid_q),
    .resRed_q(resRed_q), .resGreen_q(resGreen_q), .resBlue_q(resBlue_q),
    .resAlpha_q(resAlpha_q), .resMode_q(resMode_q));

// >>> tb/ptbd_sampler_model.sv
module ptbd_sampler_model (
    input logic sys_clk,
    input logic clkEn,
    output logic blkValid = 1'b0,
    output logic [63:0] blkData = 64'h0,
    output logic [1:0] pixX = 2'h0,
    output logic [1:0] pixY = 2'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    int stuck;
    // Held until an enabled edge takes it; no back-pressure exists
    task automatic send(logic [63:0] d, logic [3:0] p);
        blkValid <= 1'b1;
        blkData <= d;
        {pixX, pixY} <= p;
        for (int i = 0; i < 64; i++) begin
            @(posedge sys_clk);
            if (clkEn) return;
        end
        stuck++;
    endtask
    // Released data scrambled so a stale block cannot pass for fresh
    task automatic idle();
        blkValid <= 1'b0;
        blkData <= ~blkData;
    endtask
endmodule

// >>> tb/test_ptbd_decoder.sv
module test_ptbd_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic clkEn = 1'b1;
    bit stallOn;
    wire blkValid, resValid_q;
    wire [63:0] blkData;
    wire [1:0] pixX, pixY, resMode_q;
    wire [7:0] resRed_q, resGreen_q, resBlue_q, resAlpha_q;
    wire [33:0] got = {resRed_q, resGreen_q, resBlue_q, resAlpha_q, resMode_q};
    int fails, nChecks;
    logic [33:0] expQ[$];
    ptbd_sampler_model i_ptbd_sampler_model (.sys_clk(sys_clk),
        .clkEn(clkEn), .blkValid(blkValid), .blkData(blkData),
        .pixX(pixX), .pixY(pixY));
    ptbd_decoder i_ptbd_decoder (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
        .blkValid(blkValid), .blkData(blkData), .pixX(pixX), .pixY(pixY),
        .resValid_q(resValid_q), .resRed_q(resRed_q), .resGreen_q(resGreen_q),
        .resBlue_q(resBlue_q), .resAlpha_q(resAlpha_q), .resMode_q(resMode_q));
    initial forever #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) clkEn <= !stallOn || ($urandom % 4 != 0);
    function automatic logic [33:0] model(logic [63:0] d, logic [3:0] n);
        int lg[8] = '{8, 17, 29, 42, 60, 80, 106, 183};
        int sm[8] = '{2, 5, 9, 13, 18, 24, 33, 47};
        int s, sub, t, m;
        logic [1:0] ix;
        logic [33:0] r;
        r = {24'h0, 8'hFF, 2'h0};
        for (int c = 0; c < 3; c++) begin
            s = int'(d[63-8*c -: 5]) + int'($signed(d[58-8*c -: 3]));
            if (r[1:0] == 0 && (s < 0 || s > 31)) r[1:0] = 2'(c + 1);
        end
        if (r[1:0] != 0) return r;
        sub = d[32] ? n[1] : n[3];
        ix = {d[16 + n], d[n]};
        t = sub ? d[36:34] : d[39:37];
        m = ix[0] ? lg[t] : (d[33] ? sm[t] : 0);
        if (ix[1]) m = -m;
        if (!d[33] && ix == 2'h2) return 34'h0;
        for (int c = 0; c < 3; c++) begin
            s = int'(d[63-8*c -: 5]) + (sub ? int'($signed(d[58-8*c -: 3])) : 0);
            s = s * 8 + s / 4 + m;
            r[33-8*c -: 8] = 8'(s < 0 ? 0 : (s > 255 ? 255 : s));
        end
        return r;
    endfunction
    task automatic check(logic [33:0] e, logic [33:0] g);
        nChecks++;
        if (g !== e) begin
            fails++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    always @(posedge sys_clk) begin
        if (!rst && clkEn && resValid_q === 1'b1) begin
            check(expQ.size() ? expQ.pop_front() : 34'hX, got);
        end
    end
    task automatic req(logic [63:0] d, logic [3:0] n);
        i_ptbd_sampler_model.send(d, n);
        expQ.push_back(model(d, n));
    endtask
    task automatic drain();
        i_ptbd_sampler_model.idle();
        for (int i = 0; i < 300 && expQ.size() > 0; i++) @(posedge sys_clk);
        if (expQ.size() > 0) report_and_stop();
    endtask
    task automatic report_and_stop();
        fails += expQ.size() + i_ptbd_sampler_model.stuck;
        $display("checks=%0d fails=%0d", nChecks, fails);
        if (fails == 0 && nChecks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge sys_clk);
        fails++;
        report_and_stop();
    end
    initial begin
        logic [63:0] d;
        void'($urandom(32'h8AD2A75D));
        repeat (6) @(posedge sys_clk);
        #1 check(34'h0, got);
        @(posedge sys_clk);
        rst <= 1'b0;
        // Zero deltas: every table code, both opaque and split settings
        for (int k = 0; k < 256; k++) begin
            d = {$urandom, $urandom} & 64'hF8F8_F800_FFFF_FFFF;
            d[39:32] = 8'(k);
            req(d, 4'($urandom));
        end
        drain();
        stallOn = 1'b1;
        // Half the bases pinned to 0 or 31 to hit every mode boundary
        for (int k = 0; k < 600; k++) begin
            d = {$urandom, $urandom};
            for (int c = 0; c < 3 && k[0]; c++) d[63-8*c -: 5] = {5{d[62-8*c]}};
            req(d, 4'($urandom));
        end
        drain();
        stallOn = 1'b0;
        repeat (3) req({$urandom, $urandom}, 4'h5);
        rst <= 1'b1;
        i_ptbd_sampler_model.idle();
        repeat (2) @(posedge sys_clk);
        expQ.delete();
        #1 check(34'h0, got);
        @(posedge sys_clk);
        rst <= 1'b0;
        for (int k = 0; k < 16; k++) begin
            req(64'hE0C4_8A5E_0000_FFFF, 4'(k));
        end
        drain();
        report_and_stop();
    end
endmodule
